// file: rtl/mbx_pkg.sv
/*
 * Shared constants and carrier types for the four-channel interprocessor mailbox.
 * Assumes both processor ports run on the mailbox clock. Each port offers at most
 * one access per cycle.
 */
package mbx_pkg;

    // Sizes
    localparam int NUM_CH   = 4;
    localparam int NUM_PORT = 2;
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 8;

    // Port indices
    localparam int PORT_HOST = 0;
    localparam int PORT_DSP  = 1;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_H2D1_FIRST  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_H2D1_SECOND = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_D2H1_FIRST  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_D2H1_SECOND = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_D2H2_FIRST  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_D2H2_SECOND = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_H2D1_FLAG   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_D2H1_FLAG   = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_D2H2_FLAG   = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_H2D2_FIRST  = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_H2D2_SECOND = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_H2D2_FLAG   = 8'h2c;

    // Channel order: 0 host-to-dsp box1, 1 host-to-dsp box2, 2 dsp-to-host box1, 3 box2
    localparam logic [NUM_CH-1:0][ADDR_W-1:0] CH_FIRST_OFS =
        {OFS_D2H2_FIRST, OFS_D2H1_FIRST, OFS_H2D2_FIRST, OFS_H2D1_FIRST};
    localparam logic [NUM_CH-1:0][ADDR_W-1:0] CH_SECOND_OFS =
        {OFS_D2H2_SECOND, OFS_D2H1_SECOND, OFS_H2D2_SECOND, OFS_H2D1_SECOND};
    localparam logic [NUM_CH-1:0][ADDR_W-1:0] CH_FLAG_OFS =
        {OFS_D2H2_FLAG, OFS_D2H1_FLAG, OFS_H2D2_FLAG, OFS_H2D1_FLAG};

    // Bit c set: the dsp port is the sender of channel c
    localparam logic [NUM_CH-1:0] CH_SENDER_DSP = 4'hc;

    // Reset values and flag layout
    localparam logic [DATA_W-1:0] DATA_RESET   = 16'h0000;
    localparam logic              FLAG_RESET   = 1'b0;
    localparam int                FLAG_INT_BIT = 0;

    // One access request from a processor port
    typedef struct packed {
        logic              sel;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mbx_req_t;

    // Registered answer to a request
    typedef struct packed {
        logic              ack;
        logic              abort;
        logic [DATA_W-1:0] rdata;
    } mbx_rsp_t;

endpackage

// file: rtl/mbx_top.sv
/*
 * Four-channel interprocessor mailbox with a host port and a dsp port.
 * Channels 0 and 1 carry host-to-dsp messages, channels 2 and 3 dsp-to-host.
 * Each channel holds a first word, a second word and a pending flag; the
 * flag drives the receiver interrupt as a level.
 * Assumes the interrupt controller does its own masking; a masked request
 * simply stays pending here until the receiver reads the second word.
 * Assumes requests come from logic on i_clk; each answer is given one cycle
 * after the request. The bus bridge turns an abort answer into its own abort.
 */
`timescale 1ns/1ps
// Overview of operation
// - Four channels: two host-to-dsp, two dsp-to-host, each two words and a flag.
// - Sender writing the second word sets the flag and raises the receiver interrupt.
// - Writing the first word only stores it; no flag, no interrupt.
// - While the flag is set, sender writes to both words are blocked.
// - A blocked write is discarded and stored data stays unchanged.
// - A blocked write is answered with an abort to the writer.
// - Receiver reading the second word clears the flag and its interrupt.
// - Sender reading the second word leaves the flag set.
// - Sender may still read its locked words and get stored values.
// - Flag registers are read-only; writing them changes nothing.
// - Flag bit 0 shows pending; bits 15:1 read zero.
// - Each register holds 16 bits at its own word-aligned address.
// - Host writes host-to-dsp words, dsp reads them; the reverse for dsp-to-host.
// - Host-to-dsp flags are host readable; dsp reads of them are aborted, dsp writes are acked without abort.
// - After reset all words read zero and all flags read zero.
// - Masking does not clear a request; only the receiver read does.
module mbx_top
    import mbx_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic            i_resetn,
    input  wire mbx_req_t        i_host_req,
    input  wire mbx_req_t        i_dsp_req,
    output mbx_rsp_t             o_host_rsp,
    output mbx_rsp_t             o_dsp_rsp,
    output logic [1:0]           o_dsp_irq,
    output logic [1:0]           o_host_irq
);

    mbx_req_t                               req [NUM_PORT];
    mbx_rsp_t                               rsp [NUM_PORT];
    logic [NUM_PORT-1:0][NUM_CH-1:0]        hit_first;
    logic [NUM_PORT-1:0][NUM_CH-1:0]        hit_second;
    logic [NUM_PORT-1:0][NUM_CH-1:0]        hit_flag;
    logic [DATA_W-1:0]                      first_q  [NUM_CH];
    logic [DATA_W-1:0]                      second_q [NUM_CH];
    logic [NUM_CH-1:0]                      pending;
    logic [NUM_CH-1:0]                      wr_first;
    logic [NUM_CH-1:0]                      wr_second;
    logic [NUM_CH-1:0]                      lock_hit;
    logic [NUM_CH-1:0]                      rd_clear;
    logic [NUM_PORT-1:0]                    blocked;
    logic [NUM_PORT-1:0]                    denied;
    logic [NUM_PORT-1:0][DATA_W-1:0]        next_rdata;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    // Port gathering
    assign req[PORT_HOST] = i_host_req;
    assign req[PORT_DSP]  = i_dsp_req;
    assign o_host_rsp     = rsp[PORT_HOST];
    assign o_dsp_rsp      = rsp[PORT_DSP];

    assign o_dsp_irq  = pending[1:0];
    assign o_host_irq = pending[3:2];

    // Address decode, full byte address compare
    // Misaligned or unmapped addresses hit nothing and read zero
    for (genvar p = 0; p < NUM_PORT; p++) begin : g_dec
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            assign hit_first[p][c]  = req[p].sel && (req[p].addr == CH_FIRST_OFS[c]);
            assign hit_second[p][c] = req[p].sel && (req[p].addr == CH_SECOND_OFS[c]);
            assign hit_flag[p][c]   = req[p].sel && (req[p].addr == CH_FLAG_OFS[c]);
        end
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
        localparam int S = CH_SENDER_DSP[c] ? PORT_DSP : PORT_HOST;
        localparam int R = CH_SENDER_DSP[c] ? PORT_HOST : PORT_DSP;

        // only the sender writes; not while pending
        assign wr_first[c]  = req[S].wr && hit_first[S][c] && !pending[c];
        assign wr_second[c] = req[S].wr && hit_second[S][c] && !pending[c];
        assign lock_hit[c]  = req[S].wr && (hit_first[S][c] || hit_second[S][c])
                              && pending[c];
        assign rd_clear[c]  = !req[R].wr && hit_second[R][c];

        // First word storage
        always_ff @(posedge i_clk) begin
            if (!i_resetn) begin
                first_q[c] <= DATA_RESET;
            end else if (wr_first[c]) begin
                first_q[c] <= req[S].wdata;
            end
        end

        // Second word storage
        always_ff @(posedge i_clk) begin
            if (!i_resetn) begin
                second_q[c] <= DATA_RESET;
            end else if (wr_second[c]) begin
                second_q[c] <= req[S].wdata;
            end
        end

        // Pending flag, set wins over clear
        // A new message beats a stale clearing read
        always_ff @(posedge i_clk) begin
            if (!i_resetn) begin
                pending[c] <= FLAG_RESET;
            end else if (wr_second[c]) begin
                pending[c] <= 1'b1;
            end else if (rd_clear[c]) begin
                pending[c] <= 1'b0;
            end
        end

        // Second word write raises the flag, clean answer
        set_on_write_a: assert property (
            wr_second[c] |=> pending[c] ##0 rsp[S].ack && !rsp[S].abort)
            else $error("flag not set by second word write");

        // Second word takes the sender data
        second_store_a: assert property (
            wr_second[c]
            |=> second_q[c] == $past(req[S].wdata) && $stable(first_q[c]))
            else $error("second word write not stored");

        // First word write leaves the flag alone
        first_no_set_a: assert property (
            !pending[c] && wr_first[c] && !wr_second[c] |=> !pending[c])
            else $error("first word write set the flag");

        // First word takes the sender data
        first_store_a: assert property (
            wr_first[c]
            |=> first_q[c] == $past(req[S].wdata) && $stable(second_q[c]))
            else $error("first word write not stored");

        // Pending channel refuses a first word write
        lock_first_a: assert property (
            pending[c] && req[S].wr && hit_first[S][c]
            |=> $stable(first_q[c]) && rsp[S].abort)
            else $error("first word written while pending");

        // Pending channel refuses a second word write
        lock_second_a: assert property (
            pending[c] && req[S].wr && hit_second[S][c]
            |=> $stable(second_q[c]) && rsp[S].abort)
            else $error("second word written while pending");

        // Locked words keep their contents
        lock_hold_a: assert property (
            lock_hit[c] |=> $stable(first_q[c]) && $stable(second_q[c]))
            else $error("locked write changed stored data");

        // Locked write answered with abort
        abort_on_lock_a: assert property (
            lock_hit[c] |=> rsp[S].ack && rsp[S].abort)
            else $error("blocked write not aborted");

        // Receiver read drops the flag
        clear_on_read_a: assert property (
            rd_clear[c] && !wr_second[c] |=> !pending[c])
            else $error("receiver read did not clear flag");

        // Flag falls only on a receiver read or reset
        pending_drop_a: assert property (
            $fell(pending[c]) |-> $past(rd_clear[c]) || !$past(i_resetn))
            else $error("flag fell without receiver read");

        // Sender read keeps the flag
        sender_keep_a: assert property (
            pending[c] && !req[S].wr && hit_second[S][c] && !rd_clear[c] |=> pending[c])
            else $error("sender read cleared the flag");

        // Request waits for the receiver read
        pending_hold_a: assert property (
            pending[c] && !rd_clear[c] |=> pending[c])
            else $error("pending flag lost before receiver read");

        // Sender still reads its locked words
        locked_read_a: assert property (
            pending[c] && !req[S].wr && hit_first[S][c]
            |=> rsp[S].ack && rsp[S].rdata == $past(first_q[c]))
            else $error("locked read returned wrong data");

        // Same for the locked second word
        locked_second_a: assert property (
            pending[c] && !req[S].wr && hit_second[S][c]
            |=> rsp[S].ack && rsp[S].rdata == $past(second_q[c]))
            else $error("locked second word read returned wrong data");

        // Receiver writes never reach the words
        other_write_a: assert property (
            req[R].wr && (hit_first[R][c] || hit_second[R][c]) && !req[S].sel
            |=> $stable(first_q[c]) && $stable(second_q[c]) && !rsp[R].abort)
            else $error("receiver write reached channel words");

        // Sender sees the live flag
        own_flag_a: assert property (
            !req[S].wr && hit_flag[S][c]
            |=> rsp[S].rdata[FLAG_INT_BIT] == $past(pending[c]))
            else $error("flag read does not show pending state");

        // Channel empty at the release edge
        reset_value_a: assert property (
            @(posedge i_clk) $rose(i_resetn) |-> !pending[c] && first_q[c] == DATA_RESET
                                                 && second_q[c] == DATA_RESET)
            else $error("channel not cleared by reset");

        // Flag writes from either port change nothing
        flag_write_a: assert property (
            ((req[S].wr && hit_flag[S][c]) || (req[R].wr && hit_flag[R][c]))
            && !wr_second[c] && !rd_clear[c]
            |=> $stable(pending[c]))
            else $error("flag write changed the flag");
    end

    assign blocked[PORT_HOST] = |(lock_hit & ~CH_SENDER_DSP);
    assign blocked[PORT_DSP]  = |(lock_hit & CH_SENDER_DSP);

    // dsp reads of host-to-dsp flags are refused; dsp writes to them are not
    assign denied[PORT_HOST] = 1'b0;
    assign denied[PORT_DSP]  = !req[PORT_DSP].wr && |(hit_flag[PORT_DSP] & ~CH_SENDER_DSP);

    // Read data select and registered answer per port
    for (genvar p = 0; p < NUM_PORT; p++) begin : g_port
        // Read mux, unmapped reads zero
        always_comb begin
            next_rdata[p] = DATA_RESET;
            for (int c = 0; c < NUM_CH; c++) begin
                if (hit_first[p][c]) begin
                    next_rdata[p] = first_q[c];
                end
                if (hit_second[p][c]) begin
                    next_rdata[p] = second_q[c];
                end
                if (hit_flag[p][c] && !denied[p]) begin
                    // bit 0 pending, upper bits zero
                    next_rdata[p] = DATA_RESET;
                    next_rdata[p][FLAG_INT_BIT] = pending[c];
                end
            end
        end

        // Answer register, one cycle after the request
        always_ff @(posedge i_clk) begin
            if (!i_resetn) begin
                rsp[p] <= '0;
            end else begin
                rsp[p].ack   <= req[p].sel;
                rsp[p].abort <= blocked[p] || denied[p];
                rsp[p].rdata <= (req[p].sel && !req[p].wr) ? next_rdata[p] : DATA_RESET;
            end
        end

        // Reserved flag bits read zero
        flag_read_a: assert property (
            req[p].sel && !req[p].wr && |hit_flag[p] && !denied[p]
            |=> rsp[p].rdata[DATA_W-1:1] == '0)
            else $error("flag reserved bits not zero");

        // Every access answered on the next edge
        answer_each_a: assert property (
            req[p].sel |=> rsp[p].ack)
            else $error("access not answered");

        // No answer without an access
        idle_quiet_a: assert property (
            !req[p].sel |=> !rsp[p].ack && !rsp[p].abort && rsp[p].rdata == DATA_RESET)
            else $error("answer without access");

        // Among writes, only locked ones abort
        write_abort_a: assert property (
            req[p].sel && req[p].wr && !blocked[p] |=> !rsp[p].abort)
            else $error("unlocked write aborted");

        // Unmapped addresses read zero
        unmapped_read_a: assert property (
            req[p].sel && !req[p].wr && !(|hit_first[p]) && !(|hit_second[p])
            && !(|hit_flag[p])
            |=> rsp[p].rdata == DATA_RESET && !rsp[p].abort)
            else $error("unmapped read not zero");

        // Answer quiet at the release edge
        reset_answer_a: assert property (
            $rose(i_resetn) |-> !rsp[p].ack && !rsp[p].abort && rsp[p].rdata == DATA_RESET)
            else $error("answer not cleared by reset");
    end

    // Dsp reads of host-to-dsp flags refused
    deny_dsp_a: assert property (
        denied[PORT_DSP] |=> rsp[PORT_DSP].abort && rsp[PORT_DSP].rdata == DATA_RESET)
        else $error("dsp flag access not refused");

    // Host reads any flag without abort
    host_flag_a: assert property (
        req[PORT_HOST].sel && !req[PORT_HOST].wr && |hit_flag[PORT_HOST]
        |=> !rsp[PORT_HOST].abort)
        else $error("host flag read refused");

    // Each flag drives its own interrupt line
    irq_level_a: assert property (
        $rose(pending[0]) |-> $past(wr_second[0]) && o_dsp_irq[0])
        else $error("interrupt rose without second write");

    irq_box2_a: assert property (
        $rose(pending[1]) |-> $past(wr_second[1]) && o_dsp_irq[1])
        else $error("box2 interrupt rose without second write");

    host_irq_a: assert property (
        $rose(pending[2]) |-> $past(wr_second[2]) && o_host_irq[0])
        else $error("host interrupt rose without second write");

    host_box2_a: assert property (
        $rose(pending[3]) |-> $past(wr_second[3]) && o_host_irq[1])
        else $error("host box2 interrupt rose without second write");

    // Interrupt line drops only on the receiver read or reset
    irq_drop_a: assert property (
        $fell(o_dsp_irq[0]) |-> $past(rd_clear[0]) || !$past(i_resetn))
        else $error("interrupt fell without receiver read");

endmodule

// file: tb/mbx_proc_model.sv
/*
 * Bus master model of one processor port of the mailbox.
 * Assumes each access stands one cycle and is answered one cycle later.
 */
`timescale 1ns/1ps
module mbx_proc_model
    import mbx_pkg::*;
(
    input  wire logic     i_clk,
    input  wire mbx_rsp_t i_rsp,
    output mbx_req_t      o_req
);
    // Idle port from time zero
    initial begin
        o_req = '0;
    end

    // One access; released lines show the inverse of the last value
    task automatic access(input logic wr, input logic [ADDR_W-1:0] addr,
                          input logic [DATA_W-1:0] wdata, output mbx_rsp_t rsp);
        int n;
        @(posedge i_clk);
        o_req <= '{sel: 1'b1, wr: wr, addr: addr, wdata: wdata};
        @(posedge i_clk);
        o_req <= '{sel: 1'b0, wr: ~wr, addr: ~addr, wdata: ~wdata};
        rsp = '0;
        for (n = 0; n < 4; n++) begin
            @(posedge i_clk);
            if (i_rsp.ack === 1'b1) begin
                rsp = i_rsp;
                break;
            end
        end
    endtask
endmodule

// file: tb/dual_processor_mailbox_bench.sv
/*
 * Self-checking bench: message exchange, locking and refusals on all channels.
 * Assumes the host and dsp ports are driven by processor port models.
 */
`timescale 1ns/1ps
module dual_processor_mailbox_bench
    import mbx_pkg::*;
;
    logic        i_clk;
    logic        i_resetn;
    mbx_req_t    host_req;
    mbx_req_t    dsp_req;
    mbx_rsp_t    host_rsp;
    mbx_rsp_t    dsp_rsp;
    logic [1:0]  dsp_irq;
    logic [1:0]  host_irq;
    int          errors;
    int          check_count;
    int          c;
    logic        s;
    logic [7:0]  fa;
    logic [7:0]  sa;
    logic [7:0]  fl;
    logic [15:0] da;
    logic [15:0] db;

    mbx_top i_mbx_top (.i_clk(i_clk), .i_resetn(i_resetn), .i_host_req(host_req),
        .i_dsp_req(dsp_req), .o_host_rsp(host_rsp), .o_dsp_rsp(dsp_rsp),
        .o_dsp_irq(dsp_irq), .o_host_irq(host_irq));
    mbx_proc_model i_mbx_proc_model_host (.i_clk(i_clk), .i_rsp(host_rsp), .o_req(host_req));
    mbx_proc_model i_mbx_proc_model_dsp (.i_clk(i_clk), .i_rsp(dsp_rsp), .o_req(dsp_req));

    // Clock, 8 ns period
    initial begin
        i_clk = 1'b0;
    end
    always #4 i_clk = ~i_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One access on a port, then compare read data and abort
    task automatic acc(input logic port, input logic wr, input logic [7:0] addr,
                       input logic [15:0] wd, input logic [15:0] erd, input logic eab);
        mbx_rsp_t r;
        if (port) begin
            i_mbx_proc_model_dsp.access(wr, addr, wd, r);
        end else begin
            i_mbx_proc_model_host.access(wr, addr, wd, r);
        end
        if (r.ack !== 1'b1) begin
            errors++;
            final_report();
        end else begin
            check(r.rdata, erd);
            check({15'h0000, r.abort}, {15'h0000, eab});
        end
    endtask

    // Interrupt lines, bit c is channel c
    task automatic irqs(input logic [3:0] e);
        check({12'h000, host_irq, dsp_irq}, {12'h000, e});
    endtask

    // Main sequence
    initial begin
        i_resetn = 1'b0;
        errors = 0;
        check_count = 0;
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        for (c = 0; c < 'h30; c += 4) begin
            acc(1'b0, 1'b0, c[7:0], 16'h0000, 16'h0000, 1'b0);
        end
        acc(1'b0, 1'b0, 8'h30, 16'h0000, 16'h0000, 1'b0);
        acc(1'b0, 1'b0, 8'h02, 16'h0000, 16'h0000, 1'b0);
        // Full message on each channel; sender writes first word first
        for (c = 0; c < NUM_CH; c++) begin
            s = CH_SENDER_DSP[c];
            fa = CH_FIRST_OFS[c];
            sa = CH_SECOND_OFS[c];
            fl = CH_FLAG_OFS[c];
            da = 16'h1230 + 16'(c);
            db = 16'hfed0 + 16'(c);
            acc(s, 1'b1, fa, da, 16'h0000, 1'b0);
            irqs(4'h0);
            acc(!s, 1'b1, fa, 16'hdead, 16'h0000, 1'b0);
            acc(s, 1'b1, sa, db, 16'h0000, 1'b0);
            irqs(4'h1 << c);
            acc(s, 1'b0, fl, 16'h0000, 16'h0001, 1'b0);
            acc(s, 1'b1, fa, ~da, 16'h0000, 1'b1);
            irqs(4'h1 << c);
            acc(s, 1'b1, sa, ~db, 16'h0000, 1'b1);
            acc(s, 1'b1, fl, 16'h0000, 16'h0000, 1'b0);
            acc(s, 1'b0, fa, 16'h0000, da, 1'b0);
            acc(s, 1'b0, sa, 16'h0000, db, 1'b0);
            irqs(4'h1 << c);
            acc(!s, 1'b0, fl, 16'h0000, {15'h0000, s}, !s);
            acc(!s, 1'b0, fa, 16'h0000, da, 1'b0);
            acc(!s, 1'b0, sa, 16'h0000, db, 1'b0);
            irqs(4'h0);
            acc(s, 1'b0, fl, 16'h0000, 16'h0000, 1'b0);
        end
        // Both ports in the same cycle, then a reset in mid-run
        fork
            acc(1'b0, 1'b1, OFS_H2D1_FIRST, 16'h0f0f, 16'h0000, 1'b0);
            acc(1'b1, 1'b1, OFS_D2H1_FIRST, 16'hf0f0, 16'h0000, 1'b0);
        join
        acc(1'b1, 1'b0, OFS_H2D1_FIRST, 16'h0000, 16'h0f0f, 1'b0);
        acc(1'b0, 1'b0, OFS_D2H1_FIRST, 16'h0000, 16'hf0f0, 1'b0);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        acc(1'b0, 1'b0, OFS_H2D1_FIRST, 16'h0000, 16'h0000, 1'b0);
        final_report();
    end
endmodule
